// >>> ms_tick_gen.sv
// Millisecond tick generator.
// Assumes mclk free-running; emits one-cycle pulse every CYCLES clocks.
`timescale 1ns/100ps
`default_nettype none
module ms_tick_gen #(
  parameter int CYCLES = seq_pkg::MS_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_n,
  output logic tick_q
);
  import seq_pkg::*;

  logic [31:0] cnt_q;

  // ****************************************************************
  // Divider
  // ****************************************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 32'h0000_0000;
      tick_q <= 1'b0;
    end else if (cnt_q >= 32'(CYCLES - 1)) begin
      cnt_q <= 32'h0000_0000;
      tick_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 32'h0000_0001;
      tick_q <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// >>> output_sequencer.sv
// Output turn-on/turn-off sequencer with status summary byte and word.
// Assumes pins on_pin, uv_ok_pin, out_voltage_flag_low_pin, pgood_pin are async;
// event inputs and the register port come from logic on mclk.
`timescale 1ns/100ps
`default_nettype none
module output_sequencer #(
  parameter int MS_CYCLES = seq_pkg::MS_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic on_pin,
  input wire logic uv_ok_pin,
  input wire logic out_voltage_flag_low_pin,
  input wire logic pgood_pin,
  input wire logic busy_evt,
  input wire logic out_voltage_flag_ov_evt,
  input wire logic iout_oc_evt,
  input wire logic vin_uv_evt,
  input wire logic temp_evt,
  input wire logic cml_evt,
  input wire logic vendor_evt,
  input wire logic unknown_evt,
  input wire logic wr_en,
  input wire logic [3:0] wr_addr,
  input wire logic [15:0] wr_data,
  input wire logic rd_en,
  input wire logic [3:0] rd_addr,
  output logic [15:0] rd_data_q,
  output logic rd_valid_q,
  output logic power_en_q,
  output logic soft_start_q,
  output logic soft_stop_q,
  output logic ramp_fast_q,
  output logic out_voltage_flag_zero_q,
  output logic alert_n_q,
  output logic startup_timeout_evt_q,
  output logic shutdown_timeout_evt_q
);
  import seq_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic tick;
  logic [1:0] on_sync_q, uv_sync_q, low_sync_q, pg_sync_q;
  logic on_prev_q;
  logic start_cond, stop_cond;
  logic [15:0] on_delay_q, rise_q, start_lim_q, off_delay_q;
  logic [15:0] fall_q, shut_lim_q;
  logic [7:0] start_act_q;
  logic [15:0] mask_word_q;
  logic [7:0] mask_out_voltage_flag_q;
  logic [15:0] word_q;
  logic [7:0] out_voltage_flag_stat_q;
  seq_state_t state_q, state_d;
  logic [15:0] phase_ms_q;
  logic [15:0] attempt_ms_q;
  logic start_watch_q, shut_watch_q;
  logic start_to, shut_to;
  logic start_shutdown;
  logic [15:0] word_set, word_clr;
  logic [7:0] out_voltage_flag_set, out_voltage_flag_clr;
  logic [15:0] word_view;
  logic on_s, uv_ok_s, low_s, pg_s;

  // Time is up once past the setting; zero ends at once
  function automatic logic ms_done(input logic [15:0] ms,
      input logic [15:0] lim);
    ms_done = (lim == 16'h0000) || (ms > lim) || (ms == 16'hffff);
  endfunction

  ms_tick_gen #(
    .CYCLES(MS_CYCLES)
  ) u_tick (
    .mclk(mclk),
    .rst_n(rst_n),
    .tick_q(tick)
  );

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      on_sync_q <= 2'b00;
      uv_sync_q <= 2'b00;
      low_sync_q <= 2'b00;
      pg_sync_q <= 2'b00;
      on_prev_q <= 1'b0;
    end else begin
      on_sync_q <= {on_sync_q[0], on_pin};
      uv_sync_q <= {uv_sync_q[0], uv_ok_pin};
      low_sync_q <= {low_sync_q[0], out_voltage_flag_low_pin};
      pg_sync_q <= {pg_sync_q[0], pgood_pin};
      on_prev_q <= on_sync_q[1];
    end
  end

  assign on_s = on_sync_q[1];
  assign uv_ok_s = uv_sync_q[1];
  assign low_s = low_sync_q[1];
  assign pg_s = pg_sync_q[1];
  assign start_cond = on_s && !on_prev_q;
  assign stop_cond = !on_s && on_prev_q;

  // ****************************************************************
  // Timing settings
  // ****************************************************************
  // Unsigned ms settings and the start-up timeout action byte
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      on_delay_q <= ON_DELAY_RST;
      rise_q <= RISE_RST;
      start_lim_q <= START_LIM_RST;
      start_act_q <= START_ACT_RST;
      off_delay_q <= OFF_DELAY_RST;
      fall_q <= FALL_RST;
      shut_lim_q <= SHUT_LIM_RST;
    end else if (wr_en) begin
      case (wr_addr)
        ADDR_ON_DELAY: on_delay_q <= wr_data;
        ADDR_RISE: rise_q <= wr_data;
        ADDR_START_LIM: start_lim_q <= wr_data;
        ADDR_START_ACT: start_act_q <= wr_data[7:0];
        ADDR_OFF_DELAY: off_delay_q <= wr_data;
        ADDR_FALL: fall_q <= wr_data;
        ADDR_SHUT_LIM: shut_lim_q <= wr_data;
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mask_word_q <= MASK_WORD_RST;
      mask_out_voltage_flag_q <= MASK_OUT_VOLTAGE_FLAG_RST;
    end else if (wr_en && wr_addr == ADDR_MASK_WORD) begin
      mask_word_q <= wr_data;
    end else if (wr_en && wr_addr == ADDR_MASK_OUT_VOLTAGE_FLAG) begin
      mask_out_voltage_flag_q <= wr_data[7:0];
    end
  end

  // ****************************************************************
  // Sequencing state machine
  // ****************************************************************
  assign start_shutdown = start_to &&
      (start_act_q[ACT_MSB:ACT_LSB] != 2'b00);

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_OFF: begin
        if (start_cond) begin
          state_d = ST_ON_DELAY;
        end
      end
      ST_ON_DELAY: begin
        if (stop_cond) begin
          state_d = ST_OFF;
        end else if (ms_done(phase_ms_q, on_delay_q)) begin
          state_d = ST_RISE;
        end
      end
      ST_RISE: begin
        if (start_shutdown) begin
          state_d = ST_FAULT;
        end else if (stop_cond) begin
          state_d = ST_OFF_DELAY;
        end else if (ms_done(phase_ms_q, rise_q)) begin
          state_d = ST_ON;
        end
      end
      ST_ON: begin
        if (start_shutdown) begin
          state_d = ST_FAULT;
        end else if (stop_cond) begin
          state_d = ST_OFF_DELAY;
        end
      end
      ST_OFF_DELAY: begin
        if (ms_done(phase_ms_q, off_delay_q)) begin
          state_d = ST_FALL;
        end
      end
      ST_FALL: begin
        if (ms_done(phase_ms_q, fall_q)) begin
          state_d = ST_DECAY;
        end
      end
      ST_DECAY: begin
        if (low_s) begin
          state_d = ST_OFF;
        end
      end
      ST_FAULT: begin
        if (stop_cond) begin
          state_d = ST_OFF;
        end
      end
      default: state_d = ST_OFF;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      phase_ms_q <= 16'h0000;
    end else if (state_d != state_q) begin
      phase_ms_q <= 16'h0000;
    end else if (tick && phase_ms_q != 16'hffff) begin
      phase_ms_q <= phase_ms_q + 16'h0001;
    end
  end

  // ****************************************************************
  // Start-up and shutdown timeout watch
  // ****************************************************************
  // Start-up limit against undervoltage threshold
  assign start_to = start_watch_q && (start_lim_q != 16'h0000) &&
      ms_done(attempt_ms_q, start_lim_q) && !uv_ok_s;
  // Shutdown limit against 12.5 percent point
  assign shut_to = shut_watch_q && (shut_lim_q != 16'h0000) &&
      ms_done(attempt_ms_q, shut_lim_q) && !low_s;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      start_watch_q <= 1'b0;
      shut_watch_q <= 1'b0;
      attempt_ms_q <= 16'h0000;
    end else if (state_q == ST_ON_DELAY && state_d == ST_RISE) begin
      start_watch_q <= 1'b1;
      shut_watch_q <= 1'b0;
      attempt_ms_q <= 16'h0000;
    end else if (state_q == ST_OFF_DELAY && state_d == ST_FALL) begin
      start_watch_q <= 1'b0;
      shut_watch_q <= 1'b1;
      attempt_ms_q <= 16'h0000;
    end else begin
      if (uv_ok_s || start_to || stop_cond) begin
        start_watch_q <= 1'b0;
      end
      if (low_s || shut_to) begin
        shut_watch_q <= 1'b0;
      end
      if (tick && attempt_ms_q != 16'hffff) begin
        attempt_ms_q <= attempt_ms_q + 16'h0001;
      end
    end
  end

  // ****************************************************************
  // Power stage controls
  // ****************************************************************
  // Powered only in energy-transfer states
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      power_en_q <= 1'b0;
      soft_start_q <= 1'b0;
      soft_stop_q <= 1'b0;
      ramp_fast_q <= 1'b0;
      out_voltage_flag_zero_q <= 1'b1;
    end else begin
      power_en_q <= state_d == ST_RISE || state_d == ST_ON ||
          state_d == ST_OFF_DELAY || state_d == ST_FALL;
      soft_start_q <= state_d == ST_RISE;
      soft_stop_q <= state_d == ST_FALL;
      // Fastest ramp when time is zero
      ramp_fast_q <= (state_d == ST_RISE && rise_q == 16'h0000) ||
          (state_d == ST_FALL && fall_q == 16'h0000);
      out_voltage_flag_zero_q <= !(state_d == ST_RISE || state_d == ST_ON ||
          state_d == ST_OFF_DELAY || state_d == ST_FALL);
    end
  end

  // ****************************************************************
  // Status summary storage
  // ****************************************************************
  always_comb begin
    word_set = 16'h0000;
    out_voltage_flag_set = 8'h00;
    word_set[W_BUSY] = busy_evt;
    word_set[W_OUT_VOLTAGE_FLAG_OV] = out_voltage_flag_ov_evt;
    word_set[W_IOUT_OC] = iout_oc_evt;
    word_set[W_VIN_UV] = vin_uv_evt;
    word_set[W_TEMP] = temp_evt;
    word_set[W_CML] = cml_evt;
    word_set[W_IOUT] = iout_oc_evt;
    word_set[W_INPUT] = vin_uv_evt;
    word_set[W_VENDOR] = vendor_evt;
    word_set[W_UNKNOWN] = unknown_evt;
    word_set[W_UNLISTED] = start_to || shut_to;
    word_set[W_OUT_VOLTAGE_FLAG] = start_to || shut_to || out_voltage_flag_ov_evt;
    out_voltage_flag_set[V_OV] = out_voltage_flag_ov_evt;
    out_voltage_flag_set[V_START_TO] = start_to;
    out_voltage_flag_set[V_SHUT_TO] = shut_to;
  end

  always_comb begin
    word_clr = 16'h0000;
    out_voltage_flag_clr = 8'h00;
    if (wr_en && wr_addr == ADDR_STAT_WORD) begin
      word_clr = wr_data;
    end else if (wr_en && wr_addr == ADDR_STAT_BYTE) begin
      word_clr = {8'h00, wr_data[7:0]};
    end else if (wr_en && wr_addr == ADDR_OUT_VOLTAGE_FLAG_STAT) begin
      out_voltage_flag_clr = wr_data[7:0];
    end
  end

  // One store serves byte and word
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      word_q <= 16'h0000;
      out_voltage_flag_stat_q <= 8'h00;
    end else begin
      word_q <= sticky_next(word_q, word_set, word_clr) & ~LIVE_BITS;
      out_voltage_flag_stat_q <= 8'(sticky_next({8'h00, out_voltage_flag_stat_q},
          {8'h00, out_voltage_flag_set}, {8'h00, out_voltage_flag_clr}));
    end
  end

  // Fans and other-status bits stay zero
  always_comb begin
    word_view = word_q;
    word_view[W_OFF] = !power_en_q;
    word_view[W_PG_NEG] = pg_s != PG_ACTIVE_LEVEL;
  end

  // ****************************************************************
  // Read port and alert line
  // ****************************************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_q <= 16'h0000;
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= rd_en;
      if (rd_en) begin
        case (rd_addr)
          ADDR_STAT_BYTE: rd_data_q <= {8'h00, word_view[7:0]};
          ADDR_STAT_WORD: rd_data_q <= word_view;
          ADDR_OUT_VOLTAGE_FLAG_STAT: rd_data_q <= {8'h00, out_voltage_flag_stat_q};
          ADDR_MASK_WORD: rd_data_q <= mask_word_q;
          ADDR_MASK_OUT_VOLTAGE_FLAG: rd_data_q <= {8'h00, mask_out_voltage_flag_q};
          ADDR_ON_DELAY: rd_data_q <= on_delay_q;
          ADDR_RISE: rd_data_q <= rise_q;
          ADDR_START_LIM: rd_data_q <= start_lim_q;
          ADDR_START_ACT: rd_data_q <= {8'h00, start_act_q};
          ADDR_OFF_DELAY: rd_data_q <= off_delay_q;
          ADDR_FALL: rd_data_q <= fall_q;
          ADDR_SHUT_LIM: rd_data_q <= shut_lim_q;
          default: rd_data_q <= 16'h0000;
        endcase
      end
    end
  end

  // Masked bits still latch, never alert
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      alert_n_q <= 1'b1;
      startup_timeout_evt_q <= 1'b0;
      shutdown_timeout_evt_q <= 1'b0;
    end else begin
      alert_n_q <= !(|(word_q & ~mask_word_q) ||
          |(out_voltage_flag_stat_q & ~mask_out_voltage_flag_q));
      startup_timeout_evt_q <= start_to;
      shutdown_timeout_evt_q <= shut_to;
    end
  end

endmodule
`default_nettype wire

// >>> seq_chk.sv
// Assertion checker for the output sequencer ports.
// Assumes it is bound onto output_sequencer; one mclk domain.
`timescale 1ns/100ps
`default_nettype none
module seq_chk
  import seq_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic on_pin,
  input wire logic pgood_pin,
  input wire logic wr_en,
  input wire logic [3:0] wr_addr,
  input wire logic rd_en,
  input wire logic [3:0] rd_addr,
  input wire logic [15:0] rd_data_q,
  input wire logic rd_valid_q,
  input wire logic power_en_q,
  input wire logic soft_start_q,
  input wire logic soft_stop_q,
  input wire logic out_voltage_flag_zero_q,
  input wire logic startup_timeout_evt_q,
  input wire logic shutdown_timeout_evt_q
);
  logic [3:0] ra_q;
  logic [2:0] pg_cnt_q;
  logic pg_last_q;
  logic seen_q;
  logic is_word;
  logic clr_wr;
  assign is_word = rd_valid_q && ra_q == ADDR_STAT_WORD;
  assign clr_wr = wr_en && (wr_addr == ADDR_STAT_WORD ||
                            wr_addr == ADDR_OUT_VOLTAGE_FLAG_STAT);
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n) ra_q <= 4'h0;
    else if (rd_en) ra_q <= rd_addr;
  // Cycles the power-ok pin has held still
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n) begin
      pg_last_q <= 1'b0;
      pg_cnt_q <= 3'h0;
    end else begin
      pg_last_q <= pgood_pin;
      if (pgood_pin != pg_last_q) pg_cnt_q <= 3'h0;
      else if (pg_cnt_q != 3'h7) pg_cnt_q <= pg_cnt_q + 3'h1;
    end
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n) seen_q <= 1'b0;
    else if (clr_wr) seen_q <= 1'b0;
    else if (is_word) seen_q <= rd_data_q[W_OUT_VOLTAGE_FLAG];
  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  AST_OFF_LIVE: assert property (
    is_word && $stable(power_en_q) && $past(power_en_q, 2) == power_en_q
    |-> rd_data_q[W_OFF] == !power_en_q) else $error("off bit wrong");
  AST_BYTE_HIGH: assert property (
    rd_valid_q && ra_q == ADDR_STAT_BYTE |-> rd_data_q[15:8] == 8'h00)
    else $error("byte read high byte set");
  AST_WORD_UNUSED: assert property (
    is_word |-> rd_data_q[10:9] == 2'b00) else $error("unused bits set");
  AST_OUT_VOLTAGE_FLAG_UNUSED: assert property (
    rd_valid_q && ra_q == ADDR_OUT_VOLTAGE_FLAG_STAT |-> (rd_data_q & 16'hff79) == 0)
    else $error("unused status bits set");
  AST_PG_NEG: assert property (
    is_word && pg_cnt_q == 3'h7
    |-> rd_data_q[W_PG_NEG] == (pgood_pin != PG_ACTIVE_LEVEL))
    else $error("power-ok bit wrong");
  AST_STICKY: assert property (
    is_word && seen_q |-> rd_data_q[W_OUT_VOLTAGE_FLAG]) else $error("bit lost");
  AST_START_GAP: assert property (
    $rose(power_en_q) |-> $past(on_pin, 3) && soft_start_q)
    else $error("power without start");
  AST_RISE_PHASE: assert property (
    soft_start_q |-> power_en_q && !soft_stop_q && !out_voltage_flag_zero_q)
    else $error("rise phase wrong");
  AST_START_TO: assert property (
    startup_timeout_evt_q |-> $past(power_en_q) ##1 !startup_timeout_evt_q)
    else $error("start timeout wrong");
  AST_SHUT_TO: assert property (
    shutdown_timeout_evt_q |-> !power_en_q ##1 !shutdown_timeout_evt_q)
    else $error("shutdown timeout wrong");
  cover property (startup_timeout_evt_q);
  cover property (shutdown_timeout_evt_q);
  cover property (is_word && rd_data_q[W_UNLISTED]);
endmodule
bind output_sequencer seq_chk u_chk (.mclk(mclk), .rst_n(rst_n),
  .on_pin(on_pin), .pgood_pin(pgood_pin), .wr_en(wr_en),
  .wr_addr(wr_addr), .rd_en(rd_en), .rd_addr(rd_addr),
  .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q),
  .power_en_q(power_en_q), .soft_start_q(soft_start_q),
  .soft_stop_q(soft_stop_q), .out_voltage_flag_zero_q(out_voltage_flag_zero_q),
  .startup_timeout_evt_q(startup_timeout_evt_q),
  .shutdown_timeout_evt_q(shutdown_timeout_evt_q));
`default_nettype wire

// >>> seq_pkg.sv
// Constants and helpers for the output sequencer and status summary.
// Assumes a single 50 MHz device clock and unsigned-ms timing settings.
package seq_pkg;

  // ****************************************************************
  // Clock and tick timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_PERIOD_MS = 1;
  localparam int MS_CYCLES = TICK_PERIOD_MS * 1000000 / CLK_PERIOD_NS;

  // ****************************************************************
  // Register port addresses
  // ****************************************************************
  localparam logic [3:0] ADDR_STAT_BYTE = 4'h0;
  localparam logic [3:0] ADDR_STAT_WORD = 4'h1;
  localparam logic [3:0] ADDR_OUT_VOLTAGE_FLAG_STAT = 4'h2;
  localparam logic [3:0] ADDR_MASK_WORD = 4'h3;
  localparam logic [3:0] ADDR_MASK_OUT_VOLTAGE_FLAG = 4'h4;
  localparam logic [3:0] ADDR_ON_DELAY = 4'h8;
  localparam logic [3:0] ADDR_RISE = 4'h9;
  localparam logic [3:0] ADDR_START_LIM = 4'ha;
  localparam logic [3:0] ADDR_START_ACT = 4'hb;
  localparam logic [3:0] ADDR_OFF_DELAY = 4'hc;
  localparam logic [3:0] ADDR_FALL = 4'hd;
  localparam logic [3:0] ADDR_SHUT_LIM = 4'he;

  // ****************************************************************
  // Reset values of settings
  // ****************************************************************
  localparam logic [15:0] ON_DELAY_RST = 16'h0000;
  localparam logic [15:0] RISE_RST = 16'h0000;
  localparam logic [15:0] START_LIM_RST = 16'h0000;
  localparam logic [7:0] START_ACT_RST = 8'h80;
  localparam logic [15:0] OFF_DELAY_RST = 16'h0000;
  localparam logic [15:0] FALL_RST = 16'h0000;
  localparam logic [15:0] SHUT_LIM_RST = 16'h0000;
  localparam logic [15:0] MASK_WORD_RST = 16'h0000;
  localparam logic [7:0] MASK_OUT_VOLTAGE_FLAG_RST = 8'h00;

  // ****************************************************************
  // Summary word bit positions
  // ****************************************************************
  localparam int W_BUSY = 7;
  localparam int W_OFF = 6;
  localparam int W_OUT_VOLTAGE_FLAG_OV = 5;
  localparam int W_IOUT_OC = 4;
  localparam int W_VIN_UV = 3;
  localparam int W_TEMP = 2;
  localparam int W_CML = 1;
  localparam int W_UNLISTED = 0;
  localparam int W_OUT_VOLTAGE_FLAG = 15;
  localparam int W_IOUT = 14;
  localparam int W_INPUT = 13;
  localparam int W_VENDOR = 12;
  localparam int W_PG_NEG = 11;
  localparam int W_UNKNOWN = 8;
  // Bits that follow live state rather than latching
  localparam logic [15:0] LIVE_BITS = 16'h0840;

  // Output-voltage status bit positions
  localparam int V_OV = 7;
  localparam int V_START_TO = 2;
  localparam int V_SHUT_TO = 1;

  // Start-up timeout action field: 00 keeps going, else shut down
  localparam int ACT_MSB = 7;
  localparam int ACT_LSB = 6;
  localparam logic PG_ACTIVE_LEVEL = 1'b1;

  typedef enum logic [2:0] {
    ST_OFF, ST_ON_DELAY, ST_RISE, ST_ON, ST_OFF_DELAY, ST_FALL,
    ST_DECAY, ST_FAULT
  } seq_state_t;

  // Sticky update: a set in the same cycle beats the clear
  function automatic logic [15:0] sticky_next(input logic [15:0] cur,
      input logic [15:0] set, input logic [15:0] clr);
    sticky_next = (cur & ~clr) | set;
  endfunction

endpackage

// >>> smb_host.sv
// Register host model for the output sequencer.
// Assumes mclk shared with the device; one request at a time.
`timescale 1ns/100ps
`default_nettype none
module smb_host (
  input wire logic mclk,
  input wire logic [15:0] rd_data_q,
  input wire logic rd_valid_q,
  output logic wr_en,
  output logic [3:0] wr_addr,
  output logic [15:0] wr_data,
  output logic rd_en,
  output logic [3:0] rd_addr
);
  initial begin
    wr_en = 1'b0;
    wr_addr = 4'h0;
    wr_data = 16'h0000;
    rd_en = 1'b0;
    rd_addr = 4'h0;
  end
  // ****************************************************************
  // Bus tasks
  // ****************************************************************
  // 16-bit register words; ms settings unsigned
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    wr_en <= 1'b1;
    wr_addr <= a;
    wr_data <= d;
    @(posedge mclk);
    wr_en <= 1'b0;
    wr_data <= ~d;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d,
      output logic ok);
    ok = 1'b0;
    d = 16'h0000;
    @(posedge mclk);
    rd_en <= 1'b1;
    rd_addr <= a;
    @(posedge mclk);
    rd_en <= 1'b0;
    for (int i = 0; i < 4 && !ok; i++) begin
      #1;
      if (rd_valid_q === 1'b1) begin
        ok = 1'b1;
        d = rd_data_q;
      end else @(posedge mclk);
    end
  endtask
endmodule
`default_nettype wire

// >>> tb_output_sequencer.sv
// Self-checking bench for the output sequencer.
// Assumes MS_CYCLES of 10 and a simple plant behind the pins.
`timescale 1ns/100ps
`default_nettype none
module tb_output_sequencer;
  import seq_pkg::*;
  localparam int MS = 10;
  logic mclk, rst_n, on_pin, uv_ok_pin, out_voltage_flag_low_pin, pgood_pin;
  logic wr_en, rd_en, rd_valid_q, power_en_q, soft_start_q, soft_stop_q;
  logic ramp_fast_q, out_voltage_flag_zero_q, alert_n_q, st_evt, sd_evt;
  logic hold_uv, hold_hi;
  logic [3:0] wr_addr, rd_addr, sig;
  logic [7:0] evt;
  logic [15:0] wr_data, rd_data_q, lat;
  logic [15:0] ebits [8] = '{16'h0080, 16'h8020, 16'h4010, 16'h2008,
    16'h0004, 16'h0002, 16'h1000, 16'h0100};
  int n_mismatch, checked, n;
  assign sig = {soft_start_q, sd_evt, st_evt, power_en_q};
  output_sequencer #(.MS_CYCLES(MS)) uut (.mclk(mclk), .rst_n(rst_n),
    .on_pin(on_pin), .uv_ok_pin(uv_ok_pin), .out_voltage_flag_low_pin(out_voltage_flag_low_pin),
    .pgood_pin(pgood_pin), .busy_evt(evt[0]), .out_voltage_flag_ov_evt(evt[1]),
    .iout_oc_evt(evt[2]), .vin_uv_evt(evt[3]), .temp_evt(evt[4]),
    .cml_evt(evt[5]), .vendor_evt(evt[6]), .unknown_evt(evt[7]),
    .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .rd_en(rd_en),
    .rd_addr(rd_addr), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q),
    .power_en_q(power_en_q), .soft_start_q(soft_start_q),
    .soft_stop_q(soft_stop_q), .ramp_fast_q(ramp_fast_q),
    .out_voltage_flag_zero_q(out_voltage_flag_zero_q), .alert_n_q(alert_n_q),
    .startup_timeout_evt_q(st_evt), .shutdown_timeout_evt_q(sd_evt));
  smb_host host (.mclk(mclk), .rd_data_q(rd_data_q),
    .rd_valid_q(rd_valid_q), .wr_en(wr_en), .wr_addr(wr_addr),
    .wr_data(wr_data), .rd_en(rd_en), .rd_addr(rd_addr));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // Plant: output follows the power enable unless held back
  always @(posedge mclk) begin
    uv_ok_pin <= power_en_q && !hold_uv;
    pgood_pin <= power_en_q && !hold_uv;
    out_voltage_flag_low_pin <= !power_en_q && !hold_hi;
  end
  task automatic test_done;
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [15:0] e,
      input logic [15:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rdc(input logic [3:0] a, input logic [15:0] e,
      input logic [15:0] m);
    logic [15:0] d;
    logic ok;
    host.rd(a, d, ok);
    if (!ok) begin
      cmp("read answer", 16'h0001, 16'h0000);
      test_done();
    end
    cmp($sformatf("read %h", a), e & m, d & m);
  endtask
  task automatic wait_for(input int w, input logic v, input int lim,
      output int c);
    c = 0;
    do begin
      @(posedge mclk);
      #1;
      c++;
      if (c > lim) begin
        cmp("wait bound", 16'h0001, 16'h0000);
        test_done();
      end
    end while (sig[w] !== v);
  endtask
  task automatic pcycle(input int od, input int rt, input int fd,
      input int ft);
    host.wr(ADDR_ON_DELAY, 16'(od));
    host.wr(ADDR_RISE, 16'(rt));
    host.wr(ADDR_OFF_DELAY, 16'(fd));
    host.wr(ADDR_FALL, 16'(ft));
    @(posedge mclk);
    on_pin <= 1'b1;
    wait_for(0, 1'b1, (od + 1) * MS + 8, n);
    cmp("on delay", 16'(n >= od * MS), 16'h1);
    cmp("fast", {15'h0, rt == 0}, {15'h0, ramp_fast_q});
    wait_for(3, 1'b0, (rt + 1) * MS + 4, n);
    cmp("rise", 16'(n + 1 >= rt * MS), 16'h1);
    repeat (5) @(posedge mclk);
    rdc(ADDR_STAT_WORD, 16'h0000, 16'h0840);
    @(posedge mclk);
    on_pin <= 1'b0;
    wait_for(0, 1'b0, (fd + ft + 2) * MS + 8, n);
    cmp("off delay", 16'(n >= (fd + ft) * MS), 16'h1);
    cmp("zero", 16'h1, {14'h0, soft_stop_q, out_voltage_flag_zero_q});
    repeat (5) @(posedge mclk);
    rdc(ADDR_STAT_WORD, 16'h0840, 16'hffff);
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    n_mismatch = 0;
    checked = 0;
    lat = 16'h0000;
    rst_n = 1'b0;
    on_pin = 1'b0;
    evt = 8'h00;
    hold_uv = 1'b0;
    hold_hi = 1'b0;
    uv_ok_pin = 1'b0;
    pgood_pin = 1'b0;
    out_voltage_flag_low_pin = 1'b1;
    void'($urandom(44031));
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    rdc(ADDR_STAT_WORD, 16'h0840, 16'hffff);
    rdc(ADDR_STAT_BYTE, 16'h0040, 16'hffff);
    rdc(4'h5, 16'h0000, 16'hffff);
    for (int i = 0; i < 8; i++) begin
      @(posedge mclk);
      evt <= 8'h01 << i;
      @(posedge mclk);
      evt <= 8'h00;
      lat = lat | ebits[i];
      repeat ($urandom_range(3)) @(posedge mclk);
      rdc(ADDR_STAT_WORD, lat | 16'h0840, 16'hfffe);
      cmp("alert", 16'h0, {15'h0, alert_n_q});
    end
    rdc(ADDR_OUT_VOLTAGE_FLAG_STAT, 16'h0080, 16'hffff);
    rdc(ADDR_STAT_BYTE, lat & 16'h00fe | 16'h0040, 16'hfffe);
    host.wr(ADDR_STAT_WORD, 16'hffff);
    host.wr(ADDR_OUT_VOLTAGE_FLAG_STAT, 16'h00ff);
    rdc(ADDR_STAT_WORD, 16'h0840, 16'hffff);
    cmp("alert idle", 16'h1, {15'h0, alert_n_q});
    host.wr(ADDR_MASK_WORD, 16'h0004);
    @(posedge mclk);
    evt <= 8'h10;
    @(posedge mclk);
    evt <= 8'h00;
    repeat (4) @(posedge mclk);
    #1 cmp("masked alert", 16'h1, {15'h0, alert_n_q});
    rdc(ADDR_STAT_WORD, 16'h0844, 16'hffff);
    host.wr(ADDR_STAT_WORD, 16'h0004);
    host.wr(ADDR_MASK_WORD, 16'h0000);
    pcycle(0, 0, 0, 0);
    pcycle(1 + $urandom_range(2), 2, 1, 0);
    pcycle(0, 0, 0, 2);
    host.wr(ADDR_FALL, 16'h0000);
    for (int a = 0; a < 2; a++) begin
      host.wr(ADDR_START_LIM, 16'h0002);
      host.wr(ADDR_START_ACT, a ? 16'h0000 : 16'h0080);
      hold_uv <= 1'b1;
      @(posedge mclk);
      on_pin <= 1'b1;
      wait_for(1, 1'b1, 4 * MS + 20, n);
      cmp("start limit", 16'(n >= 2 * MS), 16'h1);
      repeat (3) @(posedge mclk);
      #1 cmp("kept", {15'h0, a[0]}, {15'h0, power_en_q});
      rdc(ADDR_STAT_WORD, a ? 16'h8801 : 16'h8841, 16'hffff);
      rdc(ADDR_OUT_VOLTAGE_FLAG_STAT, 16'h0004, 16'hffff);
      cmp("fault alert", 16'h0, {15'h0, alert_n_q});
      @(posedge mclk);
      on_pin <= 1'b0;
      hold_uv <= 1'b0;
      wait_for(0, 1'b0, 10 * MS, n);
      repeat (6) @(posedge mclk);
      host.wr(ADDR_STAT_WORD, 16'hffff);
      host.wr(ADDR_OUT_VOLTAGE_FLAG_STAT, 16'h00ff);
    end
    host.wr(ADDR_START_LIM, 16'h0000);
    host.wr(ADDR_SHUT_LIM, 16'h0002);
    @(posedge mclk);
    on_pin <= 1'b1;
    wait_for(0, 1'b1, 2 * MS, n);
    repeat (5) @(posedge mclk);
    hold_hi <= 1'b1;
    on_pin <= 1'b0;
    wait_for(2, 1'b1, 6 * MS, n);
    cmp("shut limit", 16'(n >= 2 * MS), 16'h1);
    rdc(ADDR_STAT_WORD, 16'h8841, 16'hffff);
    rdc(ADDR_OUT_VOLTAGE_FLAG_STAT, 16'h0002, 16'hffff);
    test_done();
  end
endmodule
`default_nettype wire
